// *** ssp_pkg.sv ***
// Constants for the synthesizer serial programming receiver
package ssp_pkg;
  localparam int unsigned SSP_SHIFT_W   = 32;
  localparam logic [5:0]  SSP_LEN_SHORT = 6'h18;
  localparam logic [5:0]  SSP_LEN_LONG  = 6'h20;
  localparam logic [5:0]  SSP_CNT_RST   = 6'h00;
  localparam int unsigned SSP_SYNC_W    = 5;
  localparam int unsigned SSP_SYNC_STRB = 0;
  localparam int unsigned SSP_SYNC_DATA = 1;
  localparam int unsigned SSP_SYNC_SCLK = 2;
  localparam int unsigned SSP_SYNC_RXC  = 3;
  localparam int unsigned SSP_SYNC_LOCK = 4;
  localparam logic [3:0]  SSP_ADDR_REF  = 4'h3;
  localparam logic [3:0]  SSP_ADDR_C    = 4'h5;
  localparam logic [3:0]  SSP_ADDR_PUMP = 4'h7;
  localparam int unsigned SSP_DIVSEL_BIT = 0;
  localparam int unsigned SSP_NR_LSB    = 12;
  localparam int unsigned SSP_FRACTION_MODULUS_LSB  = 8;
  localparam int unsigned SSP_LONG_BIT  = 7;
  localparam int unsigned SSP_CN_LSB    = 16;
  localparam int unsigned SSP_CK_LSB    = 12;
  localparam int unsigned SSP_CL_LSB    = 8;
  localparam int unsigned SSP_PR_LSB    = 6;
  localparam int unsigned SSP_NF_LSB    = 4;
  localparam int unsigned SSP_NM2_LSB   = 7;
  localparam int unsigned SSP_NM1_LSB   = 14;
  localparam int unsigned SSP_XCN_LSB   = 24;
  localparam logic [11:0] SSP_NR_RST    = 12'h000;
  localparam logic [3:0]  SSP_FRACTION_MODULUS_RST  = 4'h0;
  localparam logic [7:0]  SSP_CN_RST    = 8'h00;
  localparam logic [3:0]  SSP_ACC_RST   = 4'h0;
  localparam logic [1:0]  SSP_PR_RST    = 2'h0;
  localparam logic [2:0]  SSP_NF_RST    = 3'h0;
  localparam logic [9:0]  SSP_NM1_RST   = 10'h000;
  localparam logic [6:0]  SSP_NM2_RST   = 7'h00;
  localparam logic [23:0] SSP_WORD_RST  = 24'h000000;
endpackage : ssp_pkg

// *** ssp_sync.sv ***
// Two-flop synchronisers for the programming pins
`timescale 1ns/1ps
module ssp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end
        else
        begin
          meta_r[g] <= i_async[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign o_sync = sync_r;
endmodule : ssp_sync

// *** ssp_prog.sv ***
// Synthesizer serial programming receiver with temporary and working registers
`timescale 1ns/1ps
module ssp_prog (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_latch_strobe,
  input  wire logic        i_serial_program_line,
  input  wire logic        i_shift_clock,
  input  wire logic        i_rx_control_line,
  input  wire logic        i_loop_locked,
  output logic             o_lock_ind,
  output logic             o_rx_active,
  output logic             o_speedup,
  output logic             o_word_err,
  output logic [11:0]      o_reference_divisor,
  output logic [3:0]       o_fraction_modulus,
  output logic             o_long_flag,
  output logic [7:0]       o_charge_pump_factor,
  output logic [3:0]       o_accel_factor_one,
  output logic [3:0]       o_accel_factor_two,
  output logic [1:0]       o_divider_modulus_type,
  output logic [2:0]       o_fraction_increment,
  output logic [9:0]       o_low_modulus_cycles,
  output logic [6:0]       o_high_modulus_cycles
);
  import ssp_pkg::*;

  logic [SSP_SYNC_W-1:0] pins_async;
  logic [SSP_SYNC_W-1:0] pins_s;

  assign pins_async[SSP_SYNC_STRB] = i_latch_strobe;
  assign pins_async[SSP_SYNC_DATA] = i_serial_program_line;
  assign pins_async[SSP_SYNC_SCLK] = i_shift_clock;
  assign pins_async[SSP_SYNC_RXC]  = i_rx_control_line;
  assign pins_async[SSP_SYNC_LOCK] = i_loop_locked;

  // Three programming lines plus status pins
  ssp_sync #(.W(SSP_SYNC_W)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (pins_async),
    .o_sync  (pins_s)
  );

  // Registered state
  logic                   sclk_d_r, strb_d_r;
  logic [SSP_SHIFT_W-1:0] shift_r, shift_nxt;
  logic [5:0]             cnt_r, cnt_nxt;
  logic [23:0]            ref_tmp_r, ref_tmp_nxt;
  logic [23:0]            pump_tmp_r, pump_tmp_nxt;
  logic [23:0]            ref_wk_r, ref_wk_nxt;
  logic [23:0]            pump_wk_r, pump_wk_nxt;
  logic [23:0]            div_wk_r, div_wk_nxt;
  logic [7:0]             xcn_wk_r, xcn_wk_nxt;
  logic                   unlock_r, unlock_nxt;
  logic                   lock_r, lock_nxt;
  logic                   rx_r, rx_nxt;
  logic                   spd_r, spd_nxt;
  logic                   err_r, err_nxt;

  logic sclk_rise, strb_rise;

  assign sclk_rise = pins_s[SSP_SYNC_SCLK] & ~sclk_d_r;
  assign strb_rise = pins_s[SSP_SYNC_STRB] & ~strb_d_r;

  // Address field of a 24-bit word held in the low bits of the shifter
  function automatic logic [3:0] word_addr(input logic [SSP_SHIFT_W-1:0] w);
    word_addr = w[3:0];
  endfunction : word_addr

  always_comb
  begin
    shift_nxt    = shift_r;
    cnt_nxt      = cnt_r;
    ref_tmp_nxt  = ref_tmp_r;
    pump_tmp_nxt = pump_tmp_r;
    ref_wk_nxt   = ref_wk_r;
    pump_wk_nxt  = pump_wk_r;
    div_wk_nxt   = div_wk_r;
    xcn_wk_nxt   = xcn_wk_r;
    unlock_nxt   = unlock_r;
    err_nxt      = err_r;
    spd_nxt      = spd_r;
    // Unlock hold ends once the detector has seen the loss of lock; a new load below wins
    if (unlock_r && !pins_s[SSP_SYNC_LOCK])
    begin
      unlock_nxt = 1'b0;
    end
    if (sclk_rise && cnt_r != SSP_LEN_LONG)
    begin
      // Shift in one bit per rising clock edge until 32 bits are counted, MSB first
      shift_nxt = {shift_r[SSP_SHIFT_W-2:0], pins_s[SSP_SYNC_DATA]};
      cnt_nxt   = cnt_r + 6'h01;
    end
    if (strb_rise)
    begin
      // Latch the word on the strobe's rising edge
      cnt_nxt = SSP_CNT_RST;
      err_nxt = 1'b0;
      if (cnt_r == SSP_LEN_SHORT && !shift_r[SSP_DIVSEL_BIT])
      begin
        // Short divider word loads all working registers at once
        ref_wk_nxt  = ref_tmp_r;
        pump_wk_nxt = pump_tmp_r;
        div_wk_nxt  = shift_r[23:0];
        xcn_wk_nxt  = pump_tmp_r[SSP_CN_LSB +: 8];
        unlock_nxt  = 1'b1;
        spd_nxt     = 1'b1;
      end
      else if (cnt_r == SSP_LEN_LONG && ref_tmp_r[SSP_LONG_BIT]
               && !shift_r[SSP_DIVSEL_BIT])
      begin
        // Extended divider word carries its own pump factor
        ref_wk_nxt  = ref_tmp_r;
        pump_wk_nxt = pump_tmp_r;
        div_wk_nxt  = shift_r[23:0];
        xcn_wk_nxt  = shift_r[SSP_XCN_LSB +: 8];
        unlock_nxt  = 1'b1;
        spd_nxt     = 1'b1;
      end
      else if (cnt_r == SSP_LEN_SHORT)
      begin
        // Addressed temporary words
        case (word_addr(shift_r))
          SSP_ADDR_REF:  ref_tmp_nxt  = shift_r[23:0];
          SSP_ADDR_PUMP: pump_tmp_nxt = shift_r[23:0];
          SSP_ADDR_C:    err_nxt      = 1'b0;  // Accepted, drives nothing
          default:       err_nxt      = 1'b1;
        endcase
      end
      else
      begin
        err_nxt = 1'b1;
      end
    end
    // Speedup lasts while the strobe stays high after a divider load
    if (!pins_s[SSP_SYNC_STRB])
    begin
      spd_nxt = 1'b0;
    end
    lock_nxt = pins_s[SSP_SYNC_LOCK] & ~unlock_r & ~unlock_nxt;
    rx_nxt   = pins_s[SSP_SYNC_RXC];
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sclk_d_r   <= 1'b0;
      strb_d_r   <= 1'b0;
      shift_r    <= '0;
      cnt_r      <= SSP_CNT_RST;
      ref_tmp_r  <= SSP_WORD_RST;
      pump_tmp_r <= SSP_WORD_RST;
      ref_wk_r   <= SSP_WORD_RST;
      pump_wk_r  <= SSP_WORD_RST;
      div_wk_r   <= SSP_WORD_RST;
      xcn_wk_r   <= SSP_CN_RST;
      unlock_r   <= 1'b0;
      lock_r     <= 1'b0;
      rx_r       <= 1'b0;
      spd_r      <= 1'b0;
      err_r      <= 1'b0;
    end
    else
    begin
      sclk_d_r   <= pins_s[SSP_SYNC_SCLK];
      strb_d_r   <= pins_s[SSP_SYNC_STRB];
      shift_r    <= shift_nxt;
      cnt_r      <= cnt_nxt;
      ref_tmp_r  <= ref_tmp_nxt;
      pump_tmp_r <= pump_tmp_nxt;
      ref_wk_r   <= ref_wk_nxt;
      pump_wk_r  <= pump_wk_nxt;
      div_wk_r   <= div_wk_nxt;
      xcn_wk_r   <= xcn_wk_nxt;
      unlock_r   <= unlock_nxt;
      lock_r     <= lock_nxt;
      rx_r       <= rx_nxt;
      spd_r      <= spd_nxt;
      err_r      <= err_nxt;
    end
  end

  // Status outputs from their flag registers, field outputs straight from working registers
  assign o_lock_ind             = lock_r;
  assign o_rx_active            = rx_r;
  assign o_speedup              = spd_r;
  assign o_word_err             = err_r;
  assign o_reference_divisor    = ref_wk_r[SSP_NR_LSB +: 12];
  assign o_fraction_modulus     = ref_wk_r[SSP_FRACTION_MODULUS_LSB +: 4];
  assign o_long_flag            = ref_wk_r[SSP_LONG_BIT];
  assign o_charge_pump_factor   = xcn_wk_r;
  assign o_accel_factor_one     = pump_wk_r[SSP_CK_LSB +: 4];
  assign o_accel_factor_two     = pump_wk_r[SSP_CL_LSB +: 4];
  assign o_divider_modulus_type = pump_wk_r[SSP_PR_LSB +: 2];
  assign o_fraction_increment   = div_wk_r[SSP_NF_LSB +: 3];
  assign o_low_modulus_cycles   = div_wk_r[SSP_NM1_LSB +: 10];
  assign o_high_modulus_cycles  = div_wk_r[SSP_NM2_LSB +: 7];
endmodule : ssp_prog

// *** ssp_prog_properties.sv ***
// Concurrent checks on the programming receiver ports
`timescale 1ns/1ps
module ssp_prog_chk (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_latch_strobe,
  input wire logic        i_rx_control_line,
  input wire logic        i_loop_locked,
  input wire logic        o_lock_ind,
  input wire logic        o_rx_active,
  input wire logic        o_speedup,
  input wire logic        o_word_err,
  input wire logic [11:0] o_reference_divisor,
  input wire logic [2:0]  o_fraction_increment,
  input wire logic [9:0]  o_low_modulus_cycles
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  lock_follows_a: assert property (o_lock_ind |-> $past(i_loop_locked, 3))
    else $error("lock high without detector lock");
  rx_follow_a: assert property ($changed(o_rx_active) |->
    o_rx_active == $past(i_rx_control_line, 3)) else $error("rx active wrong");
  speedup_drop_a: assert property ($fell(i_latch_strobe) |-> ##[1:6] !o_speedup)
    else $error("speedup stuck");
  speedup_cause_a: assert property ($rose(o_speedup) |-> $past(i_latch_strobe, 3))
    else $error("speedup without strobe");
  work_hold_a: assert property (!$rose(o_speedup) |-> $stable({o_reference_divisor,
    o_fraction_increment, o_low_modulus_cycles})) else $error("fields moved");
  load_unlock_a: assert property ($rose(o_speedup) |-> !o_lock_ind)
    else $error("lock kept over load");
  err_nostore_a: assert property ($rose(o_word_err) |-> !o_speedup)
    else $error("bad word loaded");
  err_latch_a: assert property ($changed(o_word_err) |-> $past(i_latch_strobe, 3))
    else $error("error without latch");
  cover property ($rose(o_speedup));
  cover property ($rose(o_word_err));
  cover property ($rose(o_lock_ind));
endmodule : ssp_prog_chk
bind ssp_prog ssp_prog_chk ssp_prog_chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_latch_strobe(i_latch_strobe), .i_rx_control_line(i_rx_control_line),
  .i_loop_locked(i_loop_locked), .o_lock_ind(o_lock_ind), .o_rx_active(o_rx_active),
  .o_speedup(o_speedup), .o_word_err(o_word_err), .o_reference_divisor(o_reference_divisor),
  .o_fraction_increment(o_fraction_increment), .o_low_modulus_cycles(o_low_modulus_cycles));

// *** ssp_ctl_model.sv ***
// Controller model shifting words onto the programming pins
`timescale 1ns/1ps
module ssp_ctl_model (
  input  wire logic i_clk,
  output logic      o_strobe,
  output logic      o_data,
  output logic      o_sclk
);
  initial
  begin
    o_strobe = 1'b0;
    o_data = 1'b0;
    o_sclk = 1'b0;
  end
  task automatic send(input logic [31:0] w, input int len);
    for (int b = len - 1; b >= 0; b--)
    begin
      @(negedge i_clk);
      o_data = w[b];
      repeat (5) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (5) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    @(negedge i_clk);
    o_data = ~o_data;
    o_strobe = 1'b1;
  endtask : send
  task automatic drop();
    @(negedge i_clk);
    o_strobe = 1'b0;
  endtask : drop
endmodule : ssp_ctl_model

// *** tb_top.sv ***
// Self-checking bench for the programming receiver
`timescale 1ns/1ps
module tb_top;
  logic i_clk, i_rst_n, rxc, lkd, stb, sd, sck, lk, rxa, sp, er, lg;
  logic [11:0] nr;
  logic [7:0] cn;
  logic [3:0] fm, ck, cl;
  logic [1:0] pr;
  logic [2:0] nf;
  logic [9:0] m1;
  logic [6:0] m2;
  int mismatches = 0;
  int comparisons = 0;
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %0h got %0h", n, e, a); end end
  ssp_ctl_model ssp_ctl_model_i (.i_clk(i_clk), .o_strobe(stb), .o_data(sd), .o_sclk(sck));
  ssp_prog ssp_prog_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_latch_strobe(stb),
    .i_serial_program_line(sd), .i_shift_clock(sck), .i_rx_control_line(rxc),
    .i_loop_locked(lkd), .o_lock_ind(lk), .o_rx_active(rxa), .o_speedup(sp), .o_word_err(er),
    .o_reference_divisor(nr), .o_fraction_modulus(fm), .o_long_flag(lg),
    .o_charge_pump_factor(cn), .o_accel_factor_one(ck), .o_accel_factor_two(cl),
    .o_divider_modulus_type(pr), .o_fraction_increment(nf), .o_low_modulus_cycles(m1),
    .o_high_modulus_cycles(m2));
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wt
  task automatic load(input logic [31:0] w, input int len, input bit hold);
    ssp_ctl_model_i.send(w, len);
    wt(6);
    if (!hold)
      ssp_ctl_model_i.drop();
    wt(6);
  endtask : load
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (60000) @(posedge i_clk);
    mismatches++;
    print_verdict();
  end
  initial
  begin
    i_rst_n = 1'b0;
    rxc = 1'b0;
    lkd = 1'b0;
    wt(3);
    i_rst_n = 1'b1;
    `CHK("reset", 1'b0, |{nr, fm, lg, cn, ck, cl, pr, nf, m1, m2, lk, sp, er})
    load(32'h0015E883, 24, 0);
    load(32'h00582347, 24, 0);
    `CHK("nr", 12'h000, nr)
    load(32'h62270930, 32, 1);
    `CHK("speedup", 1'b1, sp)
    `CHK("lock", 1'b0, lk)
    `CHK("ref", 17'h02BD1, {nr, fm, lg})
    `CHK("pump", 18'h1888D, {cn, ck, cl, pr})
    `CHK("div", 20'h64E12, {nf, m1, m2})
    ssp_ctl_model_i.drop();
    wt(6);
    `CHK("speedup", 1'b0, sp)
    lkd = 1'b1;
    wt(6);
    `CHK("lock", 1'b1, lk)
    load(32'h00000005, 24, 0);
    `CHK("err", 1'b0, er)
    load(32'h00000009, 24, 0);
    `CHK("err", 1'b1, er)
    load(32'h00000930, 20, 0);
    `CHK("err", 1'b1, er)
    `CHK("nf", 3'h3, nf)
    load(32'h5A270940, 32, 0);
    `CHK("cn nf", 12'h5A4, {cn, 1'b0, nf})
    `CHK("lock", 1'b0, lk)
    lkd = 1'b0;
    wt(6);
    lkd = 1'b1;
    rxc = 1'b1;
    wt(6);
    `CHK("lock", 1'b1, lk)
    `CHK("rx", 1'b1, rxa)
    rxc = 1'b0;
    wt(6);
    `CHK("rx", 1'b0, rxa)
    wt(30);
    load(32'h00230503, 24, 0);
    load(32'h00270930, 24, 0);
    `CHK("ref alt", 17'h0460A, {nr, fm, lg})
    `CHK("cn short", 11'h2C3, {cn, nf})
    i_rst_n = 1'b0;
    wt(2);
    `CHK("reset", 1'b0, |{nr, cn, nf, m1, lk})
    i_rst_n = 1'b1;
    wt(4);
    print_verdict();
  end
endmodule : tb_top
